// ===== rtl/dic_pkg.sv
// Constants, register map and timing for the digital input conditioner
package dic_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int DIC_CHANNELS = 8;
    localparam int DIC_OUTPUTS  = 5;
    localparam int DIC_MV_W     = 19;
    localparam int DIC_THR_W    = 11;
    localparam int DIC_DLY_W    = 21;
    localparam int DIC_TMR_W    = 22;
    localparam int DIC_CNT_W    = 32;
    localparam int DIC_MSC_W    = 16;
    localparam int DIC_SCN_W    = 3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int TICK_MS       = 1;
    localparam int MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int SCAN_MS       = 5;
    localparam int AC_DROP_MS    = 30;
    localparam logic [DIC_SCN_W-1:0] SCAN_LAST = DIC_SCN_W'(SCAN_MS - 1);
    localparam logic [DIC_TMR_W-1:0] AC_DROP   = DIC_TMR_W'(AC_DROP_MS);
    // ------------------------------------------------------------
    // Reset values and scaling
    // ------------------------------------------------------------
    localparam logic [DIC_THR_W-1:0] ACT_THR_RST = 11'h370;
    localparam logic [DIC_THR_W-1:0] REL_THR_RST = 11'h258;
    localparam logic [DIC_THR_W-1:0] AC_REL_DIV  = 11'h00A;
    localparam logic [DIC_MV_W-1:0]  MV_PER_STEP = 19'h00064;
    localparam logic [DIC_DLY_W-1:0] DLY_RST     = 21'h000000;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_OUT_CTRL  = 12'h000;
    localparam logic [11:0] OFF_IN_STATE  = 12'h004;
    localparam logic [11:0] OFF_OUT_STATE = 12'h008;
    localparam logic [3:0]  CH_REGION     = 4'h1;
    localparam logic [2:0]  REG_CFG       = 3'h0;
    localparam logic [2:0]  REG_ACT_THR   = 3'h1;
    localparam logic [2:0]  REG_REL_THR   = 3'h2;
    localparam logic [2:0]  REG_ACT_DLY   = 3'h3;
    localparam logic [2:0]  REG_DROP_DLY  = 3'h4;
    localparam logic [2:0]  REG_COUNT     = 3'h5;
    localparam logic [2:0]  REG_VOLT      = 3'h6;
    localparam int CFG_NC_BIT = 0;
    localparam int CFG_AC_BIT = 1;
endpackage

// ===== rtl/dic_conditioner.sv
// Digital input conditioner for the eight_input_card and five_output_card
`timescale 1ns/1ps
// Summary of operation
// - Per-channel polarity picks energized level
// - Normally open: above activation threshold activates
// - Normally closed: above activation threshold deactivates
// - Normally open: below release threshold deactivates
// - Normally closed: below release threshold activates
// - Zero-to-one change waits activation delay
// - One-to-zero change waits drop-off delay
// - Alternating supply mode adds 30 ms drop
// - Alternating mode forces release to tenth
// - 32-bit counter counts reported rising changes
// - Clear command zeroes channel counter
// - Present voltage readable in millivolts
// - Settings held separately per channel
// - Five outputs each from software control
// - Outputs refreshed once per 5 ms
// - Inputs sampled once per 5 ms scan
module dic_conditioner
    import dic_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input  wire logic                                  sys_clk,
    input  wire logic                                  rst,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic [DIC_CHANNELS-1:0][DIC_MV_W-1:0] chan_mv,
    output logic      [DIC_CHANNELS-1:0]               input_state,
    output logic      [DIC_OUTPUTS-1:0]                output_channel_n
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [DIC_MV_W-1:0] thr_mv(input logic [DIC_THR_W-1:0] t);
        logic [DIC_MV_W-1:0] w;
        w = {{(DIC_MV_W-DIC_THR_W){1'b0}}, t};
        return DIC_MV_W'(w * MV_PER_STEP);
    endfunction

    function automatic logic is_chan(input logic [11:0] a);
        return a[11:8] == CH_REGION && a[4:2] <= REG_VOLT && a[1:0] == 2'b00;
    endfunction

    function automatic logic reg_hit(input logic [11:0] a, input logic [2:0] ch,
                                     input logic [2:0] r);
        return is_chan(a) && a[7:5] == ch && a[4:2] == r;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DIC_MSC_W-1:0]  ms_cnt;
    logic [DIC_SCN_W-1:0]  scan_cnt;
    logic                  ms_tick;
    logic                  scan_tick;
    logic [DIC_OUTPUTS-1:0] out_ctrl;
    logic [DIC_CHANNELS-1:0] cfg_nc;
    logic [DIC_CHANNELS-1:0] cfg_ac;
    logic [DIC_THR_W-1:0]  act_thr  [DIC_CHANNELS];
    logic [DIC_THR_W-1:0]  rel_thr  [DIC_CHANNELS];
    logic [DIC_DLY_W-1:0]  act_dly  [DIC_CHANNELS];
    logic [DIC_DLY_W-1:0]  drop_dly [DIC_CHANNELS];
    logic [DIC_TMR_W-1:0]  timer    [DIC_CHANNELS];
    logic [DIC_CNT_W-1:0]  counter  [DIC_CHANNELS];
    logic [DIC_CHANNELS-1:0] energized;

    logic [DIC_MSC_W-1:0]  next_ms_cnt;
    logic [DIC_SCN_W-1:0]  next_scan_cnt;
    logic [DIC_OUTPUTS-1:0] next_out_ctrl;
    logic [DIC_OUTPUTS-1:0] next_output_channel_n;
    logic [DIC_CHANNELS-1:0] next_cfg_nc;
    logic [DIC_CHANNELS-1:0] next_cfg_ac;
    logic [DIC_THR_W-1:0]  next_act_thr  [DIC_CHANNELS];
    logic [DIC_THR_W-1:0]  next_rel_thr  [DIC_CHANNELS];
    logic [DIC_DLY_W-1:0]  next_act_dly  [DIC_CHANNELS];
    logic [DIC_DLY_W-1:0]  next_drop_dly [DIC_CHANNELS];
    logic [DIC_TMR_W-1:0]  next_timer    [DIC_CHANNELS];
    logic [DIC_CNT_W-1:0]  next_counter  [DIC_CHANNELS];
    logic [DIC_CHANNELS-1:0] next_energized;
    logic [DIC_CHANNELS-1:0] next_input_state;
    logic [31:0]           next_prdata;

    logic                  wr_en;
    logic [2:0]            sel_ch;
    logic [2:0]            sel_reg;
    logic                  mapped;

    assign sel_ch  = paddr[7:5];
    assign sel_reg = paddr[4:2];
    assign mapped  = paddr == OFF_OUT_CTRL || paddr == OFF_IN_STATE
                     || paddr == OFF_OUT_STATE || is_chan(paddr);
    assign wr_en   = psel && penable && pwrite && mapped;
    // Zero wait states; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // Tick dividers
    // ------------------------------------------------------------
    always_comb begin
        ms_tick       = ms_cnt == DIC_MSC_W'(MS_CYCLES_P - 1);
        scan_tick     = ms_tick && scan_cnt == SCAN_LAST;
        next_ms_cnt   = ms_tick ? '0 : ms_cnt + 1'b1;
        next_scan_cnt = !ms_tick ? scan_cnt : (scan_tick ? '0 : scan_cnt + 1'b1);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ms_cnt   <= '0;
            scan_cnt <= '0;
        end else begin
            ms_cnt   <= next_ms_cnt;
            scan_cnt <= next_scan_cnt;
        end
    end

    // ------------------------------------------------------------
    // Output card
    // ------------------------------------------------------------
    always_comb begin
        next_out_ctrl         = out_ctrl;
        next_output_channel_n = output_channel_n;
        if (wr_en && paddr == OFF_OUT_CTRL) begin
            next_out_ctrl = pwdata[DIC_OUTPUTS-1:0];
        end
        // Contacts follow the controls only on the 5 ms scan tick
        if (scan_tick) begin
            next_output_channel_n = out_ctrl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_ctrl         <= '0;
            output_channel_n <= '0;
        end else begin
            out_ctrl         <= next_out_ctrl;
            output_channel_n <= next_output_channel_n;
        end
    end

    // ------------------------------------------------------------
    // Channel settings
    // ------------------------------------------------------------
    always_comb begin
        next_cfg_nc   = cfg_nc;
        next_cfg_ac   = cfg_ac;
        next_act_thr  = act_thr;
        next_rel_thr  = rel_thr;
        next_act_dly  = act_dly;
        next_drop_dly = drop_dly;
        for (int c = 0; c < DIC_CHANNELS; c++) begin
            // Every channel has its own window, so no setting is shared
            if (wr_en && reg_hit(paddr, 3'(c), REG_CFG)) begin
                next_cfg_nc[c] = pwdata[CFG_NC_BIT];
                next_cfg_ac[c] = pwdata[CFG_AC_BIT];
            end
            if (wr_en && reg_hit(paddr, 3'(c), REG_ACT_THR)) begin
                next_act_thr[c] = pwdata[DIC_THR_W-1:0];
            end
            if (wr_en && reg_hit(paddr, 3'(c), REG_REL_THR)) begin
                next_rel_thr[c] = pwdata[DIC_THR_W-1:0];
            end
            if (wr_en && reg_hit(paddr, 3'(c), REG_ACT_DLY)) begin
                next_act_dly[c] = pwdata[DIC_DLY_W-1:0];
            end
            if (wr_en && reg_hit(paddr, 3'(c), REG_DROP_DLY)) begin
                next_drop_dly[c] = pwdata[DIC_DLY_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_nc <= '0;
            cfg_ac <= '0;
            for (int c = 0; c < DIC_CHANNELS; c++) begin
                act_thr[c]  <= ACT_THR_RST;
                rel_thr[c]  <= REL_THR_RST;
                act_dly[c]  <= DLY_RST;
                drop_dly[c] <= DLY_RST;
            end
        end else begin
            cfg_nc   <= next_cfg_nc;
            cfg_ac   <= next_cfg_ac;
            act_thr  <= next_act_thr;
            rel_thr  <= next_rel_thr;
            act_dly  <= next_act_dly;
            drop_dly <= next_drop_dly;
        end
    end

    // ------------------------------------------------------------
    // Channel conditioning
    // ------------------------------------------------------------
    always_comb begin
        logic [DIC_THR_W-1:0] rel_use;
        logic [DIC_TMR_W-1:0] need;
        logic                 cand;
        rel_use = '0;
        need    = '0;
        cand    = 1'b0;
        next_energized   = energized;
        next_input_state = input_state;
        next_timer       = timer;
        next_counter     = counter;
        for (int c = 0; c < DIC_CHANNELS; c++) begin
            if (wr_en && reg_hit(paddr, 3'(c), REG_COUNT)) begin
                next_counter[c] = '0;
            end
            // Hysteresis on the sensed voltage, sampled on the scan
            rel_use = cfg_ac[c] ? DIC_THR_W'(act_thr[c] / AC_REL_DIV) : rel_thr[c];
            if (scan_tick) begin
                if (chan_mv[c] > thr_mv(act_thr[c])) begin
                    next_energized[c] = 1'b1;
                end else if (chan_mv[c] < thr_mv(rel_use)) begin
                    next_energized[c] = 1'b0;
                end
            end
            cand = energized[c] ^ cfg_nc[c];
            if (input_state[c]) begin
                need = DIC_TMR_W'(drop_dly[c]) + (cfg_ac[c] ? AC_DROP : '0);
            end else begin
                need = DIC_TMR_W'(act_dly[c]);
            end
            // Timer only runs while the candidate differs from the report
            if (cand == input_state[c]) begin
                next_timer[c] = '0;
            end else if (ms_tick && timer[c] != '1) begin
                next_timer[c] = timer[c] + 1'b1;
            end
            if (scan_tick && cand != input_state[c] && timer[c] >= need) begin
                next_input_state[c] = cand;
                next_timer[c]       = '0;
                if (cand) begin
                    // Count wins over a clear landing in the same cycle
                    next_counter[c] = counter[c] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            energized   <= '0;
            input_state <= '0;
            for (int c = 0; c < DIC_CHANNELS; c++) begin
                timer[c]   <= '0;
                counter[c] <= '0;
            end
        end else begin
            energized   <= next_energized;
            input_state <= next_input_state;
            timer       <= next_timer;
            counter     <= next_counter;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            next_prdata = '0;
            if (paddr == OFF_OUT_CTRL) begin
                next_prdata[DIC_OUTPUTS-1:0] = out_ctrl;
            end else if (paddr == OFF_IN_STATE) begin
                next_prdata[DIC_CHANNELS-1:0] = input_state;
            end else if (paddr == OFF_OUT_STATE) begin
                next_prdata[DIC_OUTPUTS-1:0] = output_channel_n;
            end else if (is_chan(paddr)) begin
                case (sel_reg)
                    REG_CFG: begin
                        next_prdata[CFG_NC_BIT] = cfg_nc[sel_ch];
                        next_prdata[CFG_AC_BIT] = cfg_ac[sel_ch];
                    end
                    REG_ACT_THR:  next_prdata[DIC_THR_W-1:0] = act_thr[sel_ch];
                    REG_REL_THR:  next_prdata[DIC_THR_W-1:0] = rel_thr[sel_ch];
                    REG_ACT_DLY:  next_prdata[DIC_DLY_W-1:0] = act_dly[sel_ch];
                    REG_DROP_DLY: next_prdata[DIC_DLY_W-1:0] = drop_dly[sel_ch];
                    REG_COUNT:    next_prdata = counter[sel_ch];
                    REG_VOLT:     next_prdata[DIC_MV_W-1:0] = chan_mv[sel_ch];
                    default:      next_prdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= '0;
        end else begin
            prdata <= next_prdata;
        end
    end
endmodule

// ===== dv/dic_conditioner_properties.sv
// Port-level assertions for the digital input conditioner
`timescale 1ns/1ps
module dic_conditioner_checker
    import dic_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input wire logic                                  sys_clk,
    input wire logic                                  rst,
    input wire logic                                  psel,
    input wire logic                                  penable,
    input wire logic                                  pwrite,
    input wire logic [11:0]                           paddr,
    input wire logic [31:0]                           pwdata,
    input wire logic [31:0]                           prdata,
    input wire logic                                  pready,
    input wire logic                                  pslverr,
    input wire logic [DIC_CHANNELS-1:0][DIC_MV_W-1:0] chan_mv,
    input wire logic [DIC_CHANNELS-1:0]               input_state,
    input wire logic [DIC_OUTPUTS-1:0]                output_channel_n
);
    // ----------------------------------------
    // Cycles since any reported state moved
    // ----------------------------------------
    localparam int SCAN_CYC = SCAN_MS * MS_CYCLES_P;
    logic [DIC_CHANNELS+DIC_OUTPUTS-1:0] seen;
    logic [31:0]                         gap;
    logic [31:0]                         next_gap;
    logic                                moved;
    assign moved = {input_state, output_channel_n} != seen;
    always_comb begin
        next_gap = (gap == 32'hFFFFFFFF) ? gap : gap + 32'h1;
        if (rst) begin
            next_gap = 32'hFFFFFFFF;
        end else if (moved) begin
            next_gap = 32'h0;
        end
    end
    always_ff @(posedge sys_clk) begin
        seen <= {input_state, output_channel_n};
        gap  <= next_gap;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence rd_setup(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence cnt_clear;
        psel && penable && pwrite && paddr == 12'h114;
    endsequence
    chk_scan_spacing: assert property (moved |-> gap >= SCAN_CYC - 1)
        else $error("state moved between scan ticks");
    chk_reset_clears: assert property ($fell(rst) |->
        input_state == '0 && output_channel_n == '0 && prdata == '0)
        else $error("state not cleared by reset");
    chk_volt_read: assert property (rd_setup(12'h118) |=> prdata == 32'($past(chan_mv[0])))
        else $error("voltage read differs from sensed level");
    chk_gap_read: assert property (rd_setup(12'h11C) |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    chk_gap_error: assert property (psel && penable && pready && paddr == 12'h11C |-> pslverr)
        else $error("unmapped access without error");
    chk_out_ok: assert property (psel && penable && paddr == OFF_OUT_CTRL |-> !pslverr)
        else $error("output control access flagged");
    chk_count_clear: assert property (cnt_clear ##2 rd_setup(12'h114) |=> prdata == 32'h0)
        else $error("counter not cleared");
endmodule
bind dic_conditioner dic_conditioner_checker #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_mv(chan_mv), .input_state(input_state), .output_channel_n(output_channel_n)
);

// ===== dv/dic_field_model.sv
// Field wiring model driving each channel's sensed voltage
`timescale 1ns/1ps
module dic_field_model
    import dic_pkg::*;
(
    input  wire logic                                  sys_clk,
    output logic      [DIC_CHANNELS-1:0][DIC_MV_W-1:0] chan_mv
);
    int unsigned level [DIC_CHANNELS] = '{default: 0};
    initial chan_mv = '0;
    // Levels land on a clock edge so the sampler never sees a half-written word
    always @(posedge sys_clk) begin
        foreach (level[c]) chan_mv[c] <= DIC_MV_W'(level[c]);
    end
    task automatic set_mv(input int c, input int unsigned mv);
        level[c] = mv;
    endtask
endmodule

// ===== dv/digital_input_conditioner_tb.sv
// Self-checking bench for the digital input conditioner
`timescale 1ns/1ps
module digital_input_conditioner_tb
    import dic_pkg::*;
;
    // ----------------------------------------
    // Clock, design and field wiring
    // ----------------------------------------
    localparam int MS = 4;
    typedef logic [DIC_CHANNELS-1:0][DIC_MV_W-1:0] dic_mv_t;
    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic [31:0]       rd;
    logic              pready;
    logic              pslverr;
    logic              err;
    dic_mv_t           chan_mv;
    logic [7:0]        input_state;
    logic [7:0]        exp_st = 8'h00;
    logic [4:0]        output_channel_n;
    int                exp_cnt [DIC_CHANNELS] = '{default: 0};
    int                n_fail = 0;
    int                total_checks = 0;
    int unsigned       v;
    always #50 sys_clk = ~sys_clk;
    dic_conditioner #(.MS_CYCLES_P(MS)) dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_mv(chan_mv), .input_state(input_state), .output_channel_n(output_channel_n));
    dic_field_model fld (.sys_clk(sys_clk), .chan_mv(chan_mv));
    // ----------------------------------------
    // Bus cycles, comparisons and the state model
    // ----------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 100) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        cmp(what, exp, rd);
    endtask
    function automatic logic [11:0] ca(input int c, input logic [2:0] r);
        return 12'h100 + 12'(c * 32) + 12'(r) * 12'h004;
    endfunction
    // Each field change is judged a fixed ms * MS cycles after it is applied, whether or not its delay has run out
    task automatic step(input int c, input int unsigned mv, input int ms, input logic val);
        fld.set_mv(c, mv);
        repeat (ms * MS) @(posedge sys_clk);
        if (val && !exp_st[c]) exp_cnt[c]++;
        exp_st[c] = val;
        @(negedge sys_clk);
        cmp("input_state", 32'(exp_st), 32'(input_state));
    endtask
    task automatic finish_test;
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'hB3B9A48F));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        for (int c = 0; c < DIC_CHANNELS; c++) begin
            rdc("cfg", ca(c, REG_CFG), 32'h0);
            rdc("act_thr", ca(c, REG_ACT_THR), 32'h370);
            rdc("rel_thr", ca(c, REG_REL_THR), 32'h258);
            rdc("act_dly", ca(c, REG_ACT_DLY), 32'h0);
            rdc("drop_dly", ca(c, REG_DROP_DLY), 32'h0);
            rdc("count", ca(c, REG_COUNT), 32'h0);
            v = $urandom_range(275000);
            fld.set_mv(c, v);
            rdc("volt", ca(c, REG_VOLT), v);
            fld.set_mv(c, 0);
        end
        xfer(1'b0, 12'h11C, 32'h0);
        cmp("unmapped_err", 32'h1, 32'(err));
        cmp("unmapped_data", 32'h0, rd);
        step(0, 0, 30, 1'b0);
        for (int c = 0; c < DIC_CHANNELS; c++) wr_clear(c);
        for (int i = 0; i < 4; i++) begin
            v = $urandom_range(31);
            xfer(1'b1, OFF_OUT_CTRL, v);
            repeat (6 * MS * 5) @(posedge sys_clk);
            @(negedge sys_clk);
            cmp("outputs", v, 32'(output_channel_n));
            rdc("out_state", OFF_OUT_STATE, v);
        end
        step(0, 88000, 20, 1'b0);
        step(0, 88100, 20, 1'b1);
        step(0, 70000, 20, 1'b1);
        step(0, 50000, 20, 1'b0);
        xfer(1'b1, ca(1, REG_CFG), 32'h1);
        step(1, 0, 20, 1'b1);
        step(1, 100000, 20, 1'b0);
        xfer(1'b1, ca(4, REG_ACT_THR), 32'hC8);
        fld.set_mv(5, 30000);
        step(4, 30000, 20, 1'b1);
        xfer(1'b1, ca(2, REG_ACT_DLY), 32'h28);
        xfer(1'b1, ca(2, REG_DROP_DLY), 32'h28);
        step(2, 100000, 30, 1'b0);
        step(2, 100000, 35, 1'b1);
        step(2, 0, 30, 1'b1);
        step(2, 0, 35, 1'b0);
        step(2, 100000, 15, 1'b0);
        step(2, 0, 60, 1'b0);
        xfer(1'b1, ca(3, REG_CFG), 32'h2);
        step(3, 100000, 20, 1'b1);
        step(3, 50000, 20, 1'b1);
        step(3, 9000, 20, 1'b1);
        step(3, 0, 25, 1'b1);
        step(3, 0, 30, 1'b0);
        for (int c = 0; c < DIC_CHANNELS; c++) rdc("count", ca(c, REG_COUNT), exp_cnt[c]);
        wr_clear(0);
        rdc("count", ca(0, REG_COUNT), 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        exp_st = 8'h00;
        exp_cnt = '{default: 0};
        rdc("out_ctrl", OFF_OUT_CTRL, 32'h0);
        rdc("act_thr", ca(4, REG_ACT_THR), 32'h370);
        rdc("count", ca(2, REG_COUNT), exp_cnt[2]);
        @(negedge sys_clk);
        cmp("input_state", 32'h0, 32'(input_state));
        finish_test();
    end
    task automatic wr_clear(input int c);
        xfer(1'b1, ca(c, REG_COUNT), 32'h0);
        exp_cnt[c] = 0;
    endtask
endmodule
